// ---- rtl/cfg_router_pkg.sv ----
// Constants and carrier types for the configuration cycle router.
package cfg_router_pkg;

    localparam logic [15:0] PTR_IO_ADDR  = 16'h0cf8;
    localparam logic [15:0] WIN_IO_ADDR  = 16'h0cfc;
    localparam logic [31:0] PTR_RESET    = 32'h0000_0000;
    localparam logic [31:0] WIN_RESET    = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES     = 32'hffff_ffff;
    localparam logic [3:0]  BE_DWORD     = 4'hf;
    localparam logic [7:0]  UPSTREAM_BUS = 8'h00;
    localparam logic [7:0]  BUS_ZERO     = 8'h00;

    localparam int ENABLE_BIT = 31;
    localparam int RSV_HI     = 30;
    localparam int RSV_LO     = 24;
    localparam int BUS_HI     = 23;
    localparam int BUS_LO     = 16;
    localparam int DEV_HI     = 15;
    localparam int DEV_LO     = 11;
    localparam int FUNC_HI    = 10;
    localparam int FUNC_LO    = 8;
    localparam int REG_HI     = 7;
    localparam int REG_LO     = 2;

    localparam logic [31:0] PTR_WR_MASK  = 32'h80ff_fffc;
    localparam logic [1:0]  TYPE1_LOW    = 2'b01;
    localparam logic [1:0]  TYPE0_LOW    = 2'b00;
    localparam int          NPORT        = 2;

    typedef enum logic [1:0] {
        TGT_INT    = 2'h0,
        TGT_HUB    = 2'h1,
        TGT_PORT_A = 2'h2,
        TGT_PORT_B = 2'h3
    } target_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } state_t;

    typedef struct packed {
        logic [7:0] first_bus;
        logic [7:0] last_bus;
        logic       link_up;
    } bridge_cfg_t;

    typedef struct packed {
        logic        valid;
        target_t     target;
        logic        io;
        logic        type1;
        logic        write;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cyc_req_t;

endpackage : cfg_router_pkg

// ---- rtl/config_cycle_router.sv ----
// Configuration access decoder that routes data window cycles to internal, hub link or ports.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: Only the pointer plus data window access method exists; no second method.
// RL2: Pointer answers dword accesses only; narrower ones go to hub link as I/O.
// RL3: Configuration cycles are made only while pointer bit 31 is set.
// RL4: Pointer holds bus in 23:16, device in 15:11, function in 10:8.
// RL5: Pointer bits 30:24 read zero; bits 1:0 are reserved and read zero.
// RL6: Register number bits 7:2 drive address bits 7:2 of generated cycles.
// RL7: With enable set, every data window access except one to a disabled port becomes a configuration cycle.
// RL8: Bus 0 hits on enabled internal devices complete internally, not on hub link.
// RL9: Bus 0 hits on disabled or absent internal devices go to hub as type 0.
// RL10: Accesses to a disabled port read all ones; writes end as master abort.
// RL11: Non-zero bus outside every port range goes to hub link as type 1.
// RL12: Bus equal to a bridge's first downstream bus gives type 0 on that port.
// RL13: Bus above first and up to last downstream bus gives type 1 on that port.
// RL14: Each port bridge's upstream bus number is fixed at zero.
// RL15: Port type 1 cycles keep pointer fields, bits 1:0 are 01, 30:24 zero.
// RL16: Bus numbers in gaps between port ranges go subtractively to the hub link.
// RL17: Software scans bus 0, then programs bridge bus ranges before going deeper.
// RL18: With enable clear, a data window access is an ordinary I/O cycle.
module config_cycle_router
    import cfg_router_pkg::*;
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset_n,
    input  wire logic                    i_ce,
    input  wire logic                    i_io_valid,
    input  wire logic                    i_io_write,
    input  wire logic [15:0]             i_io_addr,
    input  wire logic [3:0]              i_io_be,
    input  wire logic [31:0]             i_io_wdata,
    input  wire logic [31:0]             i_int_dev_en,
    input  wire bridge_cfg_t [NPORT-1:0] i_bridge,
    input  wire logic                    i_cpl_valid,
    input  wire logic                    i_cpl_abort,
    input  wire logic [31:0]             i_cpl_rdata,
    output var  cyc_req_t                o_req,
    output logic                         o_io_done,
    output logic                         o_io_abort,
    output logic [31:0]                  o_io_rdata,
    output logic                         o_busy,
    output logic [7:0]                   o_upstream_bus
);

    function automatic logic [31:0] cfg_addr(input logic [31:0] ptr, input logic t1);
        cfg_addr = {t1, 7'h00, ptr[BUS_HI:REG_LO], t1 ? TYPE1_LOW : TYPE0_LOW};
    endfunction : cfg_addr

    state_t      state_ff;
    state_t      nxt_state;
    logic [31:0] ptr_ff;
    cyc_req_t    req_ff;
    cyc_req_t    nxt_req;
    logic        done_ff;
    logic        abort_ff;
    logic [31:0] rdata_ff;
    logic        wr_ff;
    logic [7:0]  upbus_ff;
    logic        busy_ff;

    wire        accept   = i_ce && i_io_valid && (state_ff == ST_IDLE);
    wire        hit_ptr  = (i_io_addr[15:2] == PTR_IO_ADDR[15:2]);
    wire        hit_win  = (i_io_addr[15:2] == WIN_IO_ADDR[15:2]);
    wire        full_dw  = (i_io_be == BE_DWORD);
    wire        cfg_en   = ptr_ff[ENABLE_BIT];
    wire [7:0]  bus      = ptr_ff[BUS_HI:BUS_LO];
    wire [4:0]  dev      = ptr_ff[DEV_HI:DEV_LO];
    wire        bus_zero = (bus == BUS_ZERO);
    wire        int_hit  = bus_zero && i_int_dev_en[dev];

    // Only full-width pointer accesses and disabled port accesses end locally; all else forwards.
    wire        ptr_acc  = hit_ptr && full_dw; // [RL1] [RL2]
    wire        ptr_wr   = accept && ptr_acc && i_io_write;
    wire        cfg_acc  = hit_win && cfg_en; // [RL3] [RL7] [RL18]

    logic [NPORT-1:0] port_hit;
    logic [NPORT-1:0] port_first;
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        assign port_hit[p]   = !bus_zero && (bus >= i_bridge[p].first_bus)
                               && (bus <= i_bridge[p].last_bus); // [RL13] [RL16]
        assign port_first[p] = (bus == i_bridge[p].first_bus); // [RL12]
    end

    wire        any_port = |port_hit;
    wire        sel_b    = !port_hit[0];
    wire        sel_up   = sel_b ? i_bridge[1].link_up : i_bridge[0].link_up;
    wire        sel_t0   = sel_b ? port_first[1] : port_first[0];
    wire        dead     = cfg_acc && !bus_zero && any_port && !sel_up; // [RL10]

    wire        go_int   = cfg_acc && int_hit; // [RL8]
    wire        go_hub0  = cfg_acc && bus_zero && !int_hit; // [RL9]
    wire        go_port  = cfg_acc && !bus_zero && any_port && sel_up;
    wire        go_hub1  = cfg_acc && !bus_zero && !any_port; // [RL11] [RL16]
    wire        is_t1    = go_hub1 || (go_port && !sel_t0); // [RL12] [RL13]
    wire target_t port_tgt = sel_b ? TGT_PORT_B : TGT_PORT_A;
    wire target_t tgt      = go_int ? TGT_INT : (go_port ? port_tgt : TGT_HUB);
    wire        fwd      = !ptr_acc && !dead;

    always_comb begin
        nxt_req       = req_ff;
        nxt_req.valid = 1'b0;
        if (accept && fwd) begin
            nxt_req.valid  = 1'b1;
            nxt_req.target = tgt;
            nxt_req.io     = !cfg_acc; // [RL2] [RL18]
            nxt_req.type1  = is_t1;
            nxt_req.write  = i_io_write;
            nxt_req.be     = i_io_be;
            nxt_req.wdata  = i_io_wdata;
            nxt_req.addr   = cfg_acc ? cfg_addr(ptr_ff, is_t1)
                                     : {16'h0000, i_io_addr}; // [RL6] [RL15]
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = fwd ? ST_WAIT : ST_HOLD;
                end
            end
            ST_WAIT: begin
                if (i_cpl_valid) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire        fin_local = accept && !fwd;
    wire        fin_cpl   = (state_ff == ST_WAIT) && i_cpl_valid;
    wire [31:0] loc_rdata = dead ? ALL_ONES : ptr_ff; // [RL10]
    wire        loc_abort = dead && i_io_write; // [RL10]
    wire [31:0] nxt_rdata = fin_cpl ? i_cpl_rdata : loc_rdata;
    wire        nxt_abort = fin_cpl ? (i_cpl_abort && wr_ff) : loc_abort;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            req_ff   <= '0;
            done_ff  <= 1'b0;
            abort_ff <= 1'b0;
            rdata_ff <= WIN_RESET;
            wr_ff    <= 1'b0;
            upbus_ff <= UPSTREAM_BUS;
            busy_ff  <= 1'b0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ST_IDLE);
            req_ff   <= nxt_req;
            done_ff  <= fin_local || fin_cpl;
            if (fin_local || fin_cpl) begin
                rdata_ff <= nxt_rdata;
                abort_ff <= nxt_abort;
            end
            if (accept) begin
                wr_ff <= i_io_write;
            end
            upbus_ff <= UPSTREAM_BUS; // [RL14]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_ff <= PTR_RESET;
        end else if (ptr_wr) begin
            ptr_ff <= i_io_wdata & PTR_WR_MASK; // [RL4] [RL5]
        end
    end

    assign o_req          = req_ff;
    assign o_io_done      = done_ff;
    assign o_io_abort     = abort_ff;
    assign o_io_rdata     = rdata_ff;
    assign o_busy         = busy_ff;
    assign o_upstream_bus = upbus_ff;

    ptr_reserved_a: assert property ( // [RL5]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (ptr_ff[RSV_HI:RSV_LO] == 7'h00) && (ptr_ff[1:0] == 2'b00))
        else $error("Pointer reserved bits not zero.");

    ptr_store_a: assert property ( // [RL4]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        ptr_wr |=> (ptr_ff[BUS_HI:REG_LO] == $past(i_io_wdata[BUS_HI:REG_LO]))
                   && (ptr_ff[ENABLE_BIT] == $past(i_io_wdata[ENABLE_BIT])))
        else $error("Pointer fields not stored.");

    narrow_ptr_a: assert property ( // [RL2]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && hit_ptr && !full_dw |=> o_req.valid && o_req.io
                                          && (o_req.target == TGT_HUB))
        else $error("Narrow pointer access not forwarded as I/O.");

    win_disabled_a: assert property ( // [RL18]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && hit_win && !cfg_en |=> o_req.valid && o_req.io)
        else $error("Disabled window access not ordinary I/O.");

    win_config_a: assert property ( // [RL7]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && cfg_acc && !dead |=> o_req.valid && !o_req.io
            && (o_req.addr[REG_HI:REG_LO] == $past(ptr_ff[REG_HI:REG_LO])))
        else $error("Window access not turned into configuration cycle.");

    internal_bus_a: assert property ( // [RL8]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && (o_req.target == TGT_INT) |-> !o_req.type1
            && (o_req.addr[BUS_HI:BUS_LO] == BUS_ZERO))
        else $error("Internal access with non-zero bus.");

    hub_type1_a: assert property ( // [RL11]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && !o_req.io && o_req.type1 && (o_req.target == TGT_HUB)
            |-> (o_req.addr[BUS_HI:BUS_LO] != BUS_ZERO))
        else $error("Hub type 1 cycle to bus zero.");

    type1_format_a: assert property ( // [RL15]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && o_req.type1 |-> (o_req.addr[1:0] == TYPE1_LOW)
            && (o_req.addr[RSV_HI:RSV_LO] == 7'h00))
        else $error("Type 1 address format wrong.");

    dead_read_a: assert property ( // [RL10]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && accept && dead |=> o_io_done && (o_io_rdata == ALL_ONES)
            && (o_io_abort == $past(i_io_write)) && !o_req.valid)
        else $error("Disabled port access not ended locally.");

    upstream_a: assert property ( // [RL14]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_upstream_bus == UPSTREAM_BUS)
        else $error("Upstream bus number not zero.");

    bus0_hub_a: assert property ( // [RL9]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && cfg_acc && bus_zero && !i_int_dev_en[dev]
            |=> o_req.valid && (o_req.target == TGT_HUB) && !o_req.type1 && !o_req.io)
        else $error("Bus zero access to absent device not sent to hub.");

    port_first_a: assert property ( // [RL12]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && cfg_acc && !bus_zero && i_bridge[0].link_up
            && (bus == i_bridge[0].first_bus) && (bus <= i_bridge[0].last_bus)
            |=> o_req.valid && !o_req.type1 && (o_req.target == TGT_PORT_A))
        else $error("First downstream bus not a type 0 port cycle.");

    port_deep_a: assert property ( // [RL13]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && cfg_acc && !bus_zero && i_bridge[0].link_up
            && (bus > i_bridge[0].first_bus) && (bus <= i_bridge[0].last_bus)
            |=> o_req.valid && o_req.type1 && (o_req.target == TGT_PORT_A))
        else $error("Deeper bus not a type 1 port cycle.");

    gap_hub_a: assert property ( // [RL11] [RL16]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && cfg_acc && !bus_zero
            && !((bus >= i_bridge[0].first_bus) && (bus <= i_bridge[0].last_bus))
            && !((bus >= i_bridge[1].first_bus) && (bus <= i_bridge[1].last_bus))
            |=> o_req.valid && o_req.type1 && (o_req.target == TGT_HUB))
        else $error("Bus outside port ranges not a hub type 1 cycle.");

    cfg_enable_a: assert property ( // [RL3]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && !o_req.io |-> $past(ptr_ff[ENABLE_BIT]))
        else $error("Configuration cycle made with enable clear.");

    cfg_fields_a: assert property ( // [RL4] [RL15]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && !o_req.io
            |-> (o_req.addr[BUS_HI:FUNC_LO] == $past(ptr_ff[BUS_HI:FUNC_LO])))
        else $error("Bus, device or function not carried into cycle.");

    io_pass_a: assert property ( // [RL2] [RL18]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && !ptr_acc && !cfg_acc |=> o_req.valid && o_req.io
            && (o_req.addr == {16'h0000, $past(i_io_addr)}))
        else $error("Ordinary I/O cycle address not passed through.");

    ptr_hold_a: assert property ( // [RL2]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !ptr_wr |=> $stable(ptr_ff))
        else $error("Pointer changed without a dword write.");

    ptr_read_a: assert property ( // [RL5]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept && ptr_acc && !i_io_write |=> o_io_done && !o_req.valid
            && (o_io_rdata == $past(ptr_ff)))
        else $error("Pointer read not answered locally.");

    busy_quiet_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && o_busy |=> !o_req.valid)
        else $error("New request issued while busy.");

    done_busy_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_io_done |-> o_busy)
        else $error("Done pulse outside the hold state.");

    cpl_done_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && (state_ff == ST_WAIT) && i_cpl_valid
            |=> o_io_done && (o_io_rdata == $past(i_cpl_rdata)))
        else $error("Completion not handed back to the host.");

    type0_format_a: assert property ( // [RL9] [RL12]
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_req.valid && !o_req.io && !o_req.type1
            |-> (o_req.addr[ENABLE_BIT:RSV_LO] == 8'h00) && (o_req.addr[1:0] == TYPE0_LOW))
        else $error("Type 0 address format wrong.");

    ce_freeze_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_ce |=> $stable(state_ff) && $stable(ptr_ff) && $stable(o_req) && $stable(o_io_done))
        else $error("State changed while clock enable low.");

endmodule : config_cycle_router

`default_nettype wire

// ---- dv/cfg_far_model.sv ----
// Far side model answering forwarded configuration and I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module cfg_far_model
    import cfg_router_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire cyc_req_t    i_req,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_abort_en,
    output logic             o_cpl_valid,
    output logic             o_cpl_abort,
    output logic [31:0]      o_cpl_rdata
);
    logic [3:0]  cnt_ff;
    logic        wait_ff;
    logic [31:0] addr_ff;

    // One request outstanding; the answer comes after a chosen delay.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff      <= 4'h0;
            wait_ff     <= 1'b0;
            addr_ff     <= 32'h0;
            o_cpl_valid <= 1'b0;
            o_cpl_abort <= 1'b0;
            o_cpl_rdata <= 32'h1234_5678;
        end else begin
            o_cpl_valid <= 1'b0;
            o_cpl_abort <= 1'b0;
            o_cpl_rdata <= {o_cpl_rdata[30:0], ~o_cpl_rdata[31]};
            if (i_req.valid) begin
                wait_ff <= 1'b1;
                cnt_ff  <= i_delay;
                addr_ff <= i_req.addr;
            end else if (wait_ff && cnt_ff == 4'h0) begin
                wait_ff     <= 1'b0;
                o_cpl_valid <= 1'b1;
                o_cpl_abort <= i_abort_en;
                o_cpl_rdata <= ~addr_ff;
            end else if (wait_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule : cfg_far_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the configuration cycle router.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cfg_router_pkg::*;
    logic                    i_clk_sys, i_reset_n, i_io_valid, i_io_write, abort_en, ce;
    logic                    cpl_v, cpl_a, io_done, io_ab, busy, seen, ab, w;
    logic [15:0]             i_io_addr;
    logic [3:0]              i_io_be, dly;
    logic [31:0]             i_io_wdata, int_en, cpl_d, io_rd, rd, pm;
    logic [7:0]              up_bus;
    bridge_cfg_t [NPORT-1:0] br;
    cyc_req_t                req, got;
    int                      errors, check_count, n;
    logic [7:0]              tbl [8] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h05, 8'h06, 8'h0c, 8'h14};

    config_cycle_router dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ce(ce),
        .i_io_valid(i_io_valid), .i_io_write(i_io_write), .i_io_addr(i_io_addr),
        .i_io_be(i_io_be), .i_io_wdata(i_io_wdata), .i_int_dev_en(int_en), .i_bridge(br),
        .i_cpl_valid(cpl_v), .i_cpl_abort(cpl_a), .i_cpl_rdata(cpl_d), .o_req(req),
        .o_io_done(io_done), .o_io_abort(io_ab), .o_io_rdata(io_rd), .o_busy(busy),
        .o_upstream_bus(up_bus));
    cfg_far_model far (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req(req),
        .i_delay(dly), .i_abort_en(abort_en), .o_cpl_valid(cpl_v), .o_cpl_abort(cpl_a),
        .o_cpl_rdata(cpl_d));

    // Expected {target, io, type1, addr} for an access made with pointer q.
    function automatic logic [35:0] expect_req(input logic [31:0] q, input logic [15:0] a);
        logic [7:0] b;
        b = q[23:16];
        if (a != WIN_IO_ADDR || !q[31]) return {TGT_HUB, 2'b10, 32'h0};
        if (b == BUS_ZERO) begin
            return {int_en[q[15:11]] ? TGT_INT : TGT_HUB, 2'b00, 8'h00, q[23:2], 2'b00};
        end
        for (int k = 0; k < NPORT; k++) begin
            if (br[k].first_bus <= b && b <= br[k].last_bus) begin
                if (b == br[k].first_bus) return {2'(2 + k), 2'b00, 8'h00, q[23:2], 2'b00};
                return {2'(2 + k), 2'b01, 8'h80, q[23:2], 2'b01};
            end
        end
        return {TGT_HUB, 2'b01, 8'h80, q[23:2], 2'b01};
    endfunction : expect_req

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        int i;
        seen = 1'b0;
        @(negedge i_clk_sys);
        i_io_valid = 1'b1;
        i_io_write = wr;
        i_io_addr  = a;
        i_io_be    = be;
        i_io_wdata = d;
        for (i = 0; i < 64; i++) begin
            @(negedge i_clk_sys);
            i_io_valid = 1'b0;
            if (i == 0) chk("busy", 32'h1, {31'h0, busy});
            if (req.valid === 1'b1) begin
                seen = 1'b1;
                got  = req;
            end
            if (io_done === 1'b1) break;
        end
        if (i == 64) begin
            errors++;
            finish_test();
        end
        rd = io_rd;
        ab = io_ab;
        @(negedge i_clk_sys);
        chk("idle", 32'h0, {30'h0, busy, io_done});
    endtask : io

    task automatic route(input logic [15:0] a, input logic wr);
        logic [35:0] x;
        x = expect_req(pm, a);
        chk("forwarded", 32'h1, {31'h0, seen});
        chk("route", {28'h0, x[35:32]}, {28'h0, got.target, got.io, got.io ? 1'b0 : got.type1});
        if (!x[33]) chk("cfg addr", x[31:0], got.addr);
        if (x[33]) chk("io addr", {16'h0, a}, got.addr);
        chk("req write", {31'h0, wr}, {31'h0, got.write});
        chk("req be", {28'h0, i_io_be}, {28'h0, got.be});
        if (wr) chk("req data", i_io_wdata, got.wdata);
        if (!wr) chk("rdata", ~got.addr, rd);
    endtask : route

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        errors = 0;
        check_count = 0;
        void'($urandom(32'h5c2c));
        {i_reset_n, i_io_valid, i_io_write, abort_en, i_io_addr, i_io_be, i_io_wdata} = '0;
        ce = 1'b1;
        br = '0;
        int_en = 32'h0000_0015;
        dly = 4'h0;
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        chk("upstream", 32'h0, {24'h0, up_bus});
        pm = $urandom();
        io(1'b1, PTR_IO_ADDR, BE_DWORD, pm);
        io(1'b0, PTR_IO_ADDR, BE_DWORD, 32'h0);
        chk("pointer", pm & PTR_WR_MASK, rd);
        chk("ptr local", 32'h0, {31'h0, seen});
        io(1'b1, PTR_IO_ADDR, 4'h3, $urandom());
        route(PTR_IO_ADDR, 1'b1);
        pm = pm & 32'h7fff_fffc;
        io(1'b1, PTR_IO_ADDR, BE_DWORD, pm);
        io(1'b0, WIN_IO_ADDR, BE_DWORD, 32'h0);
        route(WIN_IO_ADDR, 1'b0);
        for (n = 0; n < 40; n++) begin
            pm = {8'h80, (n < 8) ? tbl[n] : 8'($urandom_range(0, 15)), 14'($urandom()), 2'b00};
            if (n < 2) pm[15:11] = 5'(n);
            if (n == 2) begin
                br[0] = '{8'h02, 8'h05, 1'b1};
                br[1] = '{8'h08, 8'h0c, 1'b1};
            end
            dly = 4'($urandom());
            w = 1'($urandom());
            io(1'b1, PTR_IO_ADDR, BE_DWORD, pm);
            io(w, WIN_IO_ADDR, BE_DWORD, $urandom());
            route(WIN_IO_ADDR, w);
        end
        br[1].link_up = 1'b0;
        pm = 32'h8009_1a04;
        io(1'b1, PTR_IO_ADDR, BE_DWORD, pm);
        io(1'b0, WIN_IO_ADDR, BE_DWORD, 32'h0);
        chk("dead read", ALL_ONES, rd);
        chk("dead req", 32'h0, {31'h0, seen});
        io(1'b1, WIN_IO_ADDR, BE_DWORD, $urandom());
        chk("dead abort", 32'h1, {31'h0, ab});
        abort_en = 1'b1;
        pm = 32'h8004_0808;
        io(1'b1, PTR_IO_ADDR, BE_DWORD, pm);
        io(1'b1, WIN_IO_ADDR, BE_DWORD, $urandom());
        chk("fwd abort", 32'h1, {31'h0, ab});
        @(negedge i_clk_sys);
        ce = 1'b0;
        {i_io_valid, i_io_write, i_io_addr, i_io_be, i_io_wdata} = {2'b11, PTR_IO_ADDR, BE_DWORD, ~pm};
        repeat (2) @(negedge i_clk_sys);
        {ce, i_io_valid} = 2'b10;
        chk("frozen done", 32'h0, {31'h0, io_done});
        io(1'b0, PTR_IO_ADDR, BE_DWORD, 32'h0);
        chk("frozen ptr", pm & PTR_WR_MASK, rd);
        i_reset_n = 1'b0;
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        io(1'b0, PTR_IO_ADDR, BE_DWORD, 32'h0);
        chk("reset ptr", PTR_RESET, rd);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
